/* File: hw/aac_top.sv */
// acquisition control: conversion starts, result fifo, triggers, counters, scanning
//
// Local design decisions: the address-and-strobe port and the address map.
`include "aac_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - soft strobe access starts one conversion
// - low pulse on convert pin starts conversion when acquisition is off or running with external timing
// - finished conversion pushes result into fifo
// - not-empty flag shows results are held
// - fifo read pops oldest, updates not-empty
// - empty fifo read returns meaningless data
// - push beyond 512 sets sticky overflow
// - start during busy conversion sets overrun
// - counters reload at end, stay armed
// - posttrigger counts after first trigger
// - pretrigger counts only after second trigger
// - start strobe write triggers acquisition
// - trigger pin falling edge triggers acquisition
// - continuous scan repeats until count ends
// - passes follow back to back
// - scan only with both enable bits
// - interval enable imposes scan interval
// - interval counter starts at pass start
// - next pass waits for interval terminal
// - clear strobe clears flags and fifo
// - marked entry ends pass, then wrap
// - pointer advance per conversion or counter pulse
// - zero sample count write stands for 65536 samples
module aac_top #(
  parameter int DW          = 16,
  parameter int FIFO_DEPTH  = 512,
  parameter int FIFO_AW     = 9,
  parameter int CFG_DEPTH   = 16,
  parameter int CFG_AW      = 4,
  parameter int CNT_W       = 17
) (
  input  wire logic          mclk_i,
  input  wire logic          reset_n_i,
  input  wire logic [7:0]    addr_i,
  input  wire logic [DW-1:0] wdata_i,
  input  wire logic          wr_i,
  input  wire logic          rd_i,
  output logic      [DW-1:0] rdata_o,
  input  wire logic          ext_convert_n_i,
  input  wire logic          ext_trigger_n_i,
  input  wire logic          counter_one_output_n_i,
  input  wire logic [DW-1:0] adc_data_i,
  output logic               adc_start_o,
  output logic      [DW-2:0] adc_config_o,
  output logic               result_fifo_not_empty_o
);

  localparam int CONV_CYCLES = (`AAC_CONV_TIME_NS + `AAC_CLK_PERIOD_NS - 1) / `AAC_CLK_PERIOD_NS;

  // ***********************************
  // helpers
  // ***********************************
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  function automatic logic fall(input logic prev, input logic cur);
    fall = prev && !cur;
  endfunction : fall

  // ***********************************
  // pin synchronisers and edge detect
  // ***********************************
  logic [2:0] conv_sync_reg,  conv_sync_next;
  logic [2:0] trig_sync_reg,  trig_sync_next;
  logic [2:0] c1_sync_reg,    c1_sync_next;
  logic       ext_conv_fall, ext_trig_fall, c1_fall;

  always_comb begin
    // bit 0 is the first stage and only feeds bit 1
    conv_sync_next = {conv_sync_reg[1:0], ext_convert_n_i};
    trig_sync_next = {trig_sync_reg[1:0], ext_trigger_n_i};
    c1_sync_next   = {c1_sync_reg[1:0],   counter_one_output_n_i};
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      conv_sync_reg <= 3'h7;
      trig_sync_reg <= 3'h7;
      c1_sync_reg   <= 3'h7;
    end else begin
      conv_sync_reg <= conv_sync_next;
      trig_sync_reg <= trig_sync_next;
      c1_sync_reg   <= c1_sync_next;
    end
  end

  assign ext_conv_fall = fall(conv_sync_reg[2], conv_sync_reg[1]);
  assign ext_trig_fall = fall(trig_sync_reg[2], trig_sync_reg[1]);
  assign c1_fall       = fall(c1_sync_reg[2],   c1_sync_reg[1]);

  // ***********************************
  // register bus decode
  // ***********************************
  logic soft_convert_strobe, acquisition_start_strobe, acquisition_clear_strobe;
  logic fifo_pop, cfg_write, cfg_clear;

  // any access to the strobe offset starts a conversion
  assign soft_convert_strobe      = (wr_i || rd_i) && hit(addr_i, `AAC_OFS_SOFT_CONVERT);
  assign acquisition_start_strobe = wr_i && hit(addr_i, `AAC_OFS_ACQ_START);
  assign acquisition_clear_strobe = (wr_i || rd_i) && hit(addr_i, `AAC_OFS_ACQ_CLEAR);
  assign fifo_pop                 = rd_i && hit(addr_i, `AAC_OFS_RESULT_FIFO);
  assign cfg_write                = wr_i && hit(addr_i, `AAC_OFS_CFG_MEM);
  assign cfg_clear                = (wr_i || rd_i) && hit(addr_i, `AAC_OFS_CFG_MEM_CLR);

  // ***********************************
  // software-written settings
  // ***********************************
  logic [`AAC_CMD_W-1:0] command_reg,      command_next;
  logic [DW-1:0]         sample_ival_reg,  sample_ival_next;
  logic [CNT_W-1:0]      sample_count_reg, sample_count_next;
  logic [DW-1:0]         scan_ival_reg,    scan_ival_next;
  logic scan_enable, acquisition_enable, scan_interval_enable;
  logic scan_division_enable, pretrigger_mode, internal_timing, scanning;

  always_comb begin
    command_next      = command_reg;
    sample_ival_next  = sample_ival_reg;
    sample_count_next = sample_count_reg;
    scan_ival_next    = scan_ival_reg;
    if (wr_i) begin
      if (hit(addr_i, `AAC_OFS_COMMAND))      command_next      = wdata_i[`AAC_CMD_W-1:0];
      if (hit(addr_i, `AAC_OFS_SAMPLE_IVAL))  sample_ival_next  = wdata_i;
      // a zero write stands for the top count, one more than the field holds
      if (hit(addr_i, `AAC_OFS_SAMPLE_COUNT)) sample_count_next = {wdata_i == '0, wdata_i};
      if (hit(addr_i, `AAC_OFS_SCAN_IVAL))    scan_ival_next    = wdata_i;
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      command_reg      <= `AAC_RST_COMMAND;
      sample_ival_reg  <= `AAC_RST_SAMPLE_IVAL;
      sample_count_reg <= `AAC_RST_SAMPLE_COUNT;
      scan_ival_reg    <= `AAC_RST_SCAN_IVAL;
    end else begin
      command_reg      <= command_next;
      sample_ival_reg  <= sample_ival_next;
      sample_count_reg <= sample_count_next;
      scan_ival_reg    <= scan_ival_next;
    end
  end

  assign scan_enable          = command_reg[`AAC_CMD_SCAN_EN];
  assign acquisition_enable   = command_reg[`AAC_CMD_ACQ_EN];
  assign scan_interval_enable = command_reg[`AAC_CMD_SCAN_IVAL_EN];
  assign scan_division_enable = command_reg[`AAC_CMD_SCAN_DIV_EN];
  assign pretrigger_mode      = command_reg[`AAC_CMD_PRETRIG];
  assign internal_timing      = command_reg[`AAC_CMD_INT_TIMING];
  assign scanning             = scan_enable && acquisition_enable;

  // ***********************************
  // acquisition sequencer and counters
  // ***********************************
  aac_pkg::aac_acq_state_t acq_state_reg, acq_state_next;
  logic [CNT_W-1:0] samples_left_reg, samples_left_next;
  logic [DW-1:0]    ival_cnt_reg,     ival_cnt_next;
  logic [DW-1:0]    scan_cnt_reg,     scan_cnt_next;
  logic             pass_hold_reg,    pass_hold_next;
  logic             acq_trigger, acq_run, acq_tick, acq_conv_req;
  logic             conv_start, pass_start, pass_end, scan_tc;
  logic             seq_at_first, seq_last, seq_advance;

  assign acq_trigger = acquisition_enable && (acquisition_start_strobe || ext_trig_fall);
  assign acq_run     = (acq_state_reg != aac_pkg::AAC_ACQ_IDLE);
  assign acq_tick    = internal_timing ? (ival_cnt_reg == 16'h0001) : ext_conv_fall;
  // no starts while the last pass waits out its interval
  assign acq_conv_req = acq_run && acq_tick && !pass_hold_reg;
  assign scan_tc      = (scan_cnt_reg <= 16'h0001);
  assign pass_start   = conv_start && scanning && seq_at_first;
  assign pass_end     = seq_advance && seq_last;

  always_comb begin
    acq_state_next    = acq_state_reg;
    samples_left_next = samples_left_reg;
    ival_cnt_next     = ival_cnt_reg;
    scan_cnt_next     = scan_cnt_reg;
    pass_hold_next    = pass_hold_reg;
    if (acq_run && internal_timing) begin
      ival_cnt_next = (ival_cnt_reg <= 16'h0001) ? sample_ival_reg : ival_cnt_reg - 1'b1;
    end
    if (scan_interval_enable && scanning) begin
      if (pass_start)   scan_cnt_next = scan_ival_reg;
      else if (!scan_tc) scan_cnt_next = scan_cnt_reg - 1'b1;
    end
    if (pass_hold_reg && scan_tc) pass_hold_next = 1'b0;
    if (pass_end && scan_interval_enable && scanning && !scan_tc) begin
      pass_hold_next = 1'b1;
    end
    case (acq_state_reg)
      aac_pkg::AAC_ACQ_IDLE: begin
        if (acq_trigger) begin
          samples_left_next = sample_count_reg;
          ival_cnt_next     = sample_ival_reg;
          acq_state_next    = pretrigger_mode ? aac_pkg::AAC_ACQ_PRE_WAIT
                                              : aac_pkg::AAC_ACQ_COUNTING;
        end
      end
      aac_pkg::AAC_ACQ_PRE_WAIT: begin
        if (acq_trigger) acq_state_next = aac_pkg::AAC_ACQ_COUNTING;
      end
      aac_pkg::AAC_ACQ_COUNTING: begin
        if (conv_start && samples_left_reg != '0) samples_left_next = samples_left_reg - 1'b1;
        if (conv_start && samples_left_reg <= 17'h00001) begin
          // reload so the next trigger needs no reprogramming
          samples_left_next = sample_count_reg;
          ival_cnt_next     = sample_ival_reg;
          pass_hold_next    = 1'b0;
          acq_state_next    = aac_pkg::AAC_ACQ_IDLE;
        end
      end
      default: acq_state_next = aac_pkg::AAC_ACQ_IDLE;
    endcase
    if (!acquisition_enable) begin
      acq_state_next = aac_pkg::AAC_ACQ_IDLE;
      pass_hold_next = 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      acq_state_reg    <= aac_pkg::AAC_ACQ_IDLE;
      samples_left_reg <= '0;
      ival_cnt_reg     <= '0;
      scan_cnt_reg     <= '0;
      pass_hold_reg    <= 1'b0;
    end else begin
      acq_state_reg    <= acq_state_next;
      samples_left_reg <= samples_left_next;
      ival_cnt_reg     <= ival_cnt_next;
      scan_cnt_reg     <= scan_cnt_next;
      pass_hold_reg    <= pass_hold_next;
    end
  end

  // ***********************************
  // conversion engine and error flags
  // ***********************************
  logic [15:0]     conv_cnt_reg,      conv_cnt_next;
  logic            conv_busy_reg,     conv_busy_next;
  logic            overflow_reg,      overflow_next;
  logic            overrun_reg,       overrun_next;
  logic            complete_reg,      complete_next;
  logic [DW-2:0]   adc_config_reg,    adc_config_next;
  logic            start_req, conv_done, fifo_full, fifo_not_empty;
  logic [DW-1:0]   fifo_head;
  logic [DW-2:0]   seq_cfg;

  // with acquisition disabled the convert pin gives single conversions
  assign start_req  = soft_convert_strobe || acq_conv_req ||
                      (!acq_run && !acquisition_enable && ext_conv_fall);
  assign conv_start = start_req && !conv_busy_reg;
  assign conv_done  = conv_busy_reg && (conv_cnt_reg == 16'h0001);

  always_comb begin
    conv_busy_next  = conv_busy_reg;
    conv_cnt_next   = conv_cnt_reg;
    adc_config_next = adc_config_reg;
    overflow_next   = overflow_reg;
    overrun_next    = overrun_reg;
    complete_next   = complete_reg;
    if (conv_busy_reg) conv_cnt_next = conv_cnt_reg - 1'b1;
    if (conv_done)     conv_busy_next = 1'b0;
    if (conv_start) begin
      conv_busy_next  = 1'b1;
      conv_cnt_next   = 16'(CONV_CYCLES);
      adc_config_next = seq_cfg;
    end
    // clear first, so a same-cycle event still sets its flag
    if (acquisition_clear_strobe) begin
      overflow_next = 1'b0;
      overrun_next  = 1'b0;
      complete_next = 1'b0;
    end
    if (conv_done && fifo_full && !fifo_pop) overflow_next = 1'b1;
    if (start_req && conv_busy_reg)          overrun_next  = 1'b1;
    if (acq_state_reg == aac_pkg::AAC_ACQ_COUNTING &&
        acq_state_next == aac_pkg::AAC_ACQ_IDLE) complete_next = 1'b1;
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      conv_busy_reg  <= 1'b0;
      conv_cnt_reg   <= '0;
      adc_config_reg <= '0;
      overflow_reg   <= 1'b0;
      overrun_reg    <= 1'b0;
      complete_reg   <= 1'b0;
    end else begin
      conv_busy_reg  <= conv_busy_next;
      conv_cnt_reg   <= conv_cnt_next;
      adc_config_reg <= adc_config_next;
      overflow_reg   <= overflow_next;
      overrun_reg    <= overrun_next;
      complete_reg   <= complete_next;
    end
  end

  assign adc_start_o  = conv_start;
  assign adc_config_o = adc_config_reg;

  // ***********************************
  // result fifo
  // ***********************************
  // push on completion with no software action; a pop frees room the same cycle
  aac_result_fifo #(
    .W     (DW),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .mclk_i      (mclk_i),
    .reset_n_i   (reset_n_i),
    .clear_i     (acquisition_clear_strobe),
    .push_i      (conv_done),
    .push_data_i (adc_data_i),
    .pop_i       (fifo_pop),
    .head_o      (fifo_head),
    .not_empty_o (fifo_not_empty),
    .full_o      (fifo_full)
  );

  // flag follows the count, which moves only on a real push, a real pop or a clear
  assign result_fifo_not_empty_o = fifo_not_empty;

  // ***********************************
  // scan sequence
  // ***********************************
  // scan division steps on the counter pulse; otherwise after every conversion
  assign seq_advance = scanning && (scan_division_enable ? c1_fall : conv_done);

  aac_scan_seq #(
    .W     (DW),
    .DEPTH (CFG_DEPTH),
    .AW    (CFG_AW)
  ) u_seq (
    .mclk_i       (mclk_i),
    .reset_n_i    (reset_n_i),
    .clear_i      (cfg_clear),
    .write_i      (cfg_write),
    .write_data_i (wdata_i),
    // without scanning the first entry is the single channel
    .restart_i    (!scanning || (acq_trigger && !acq_run)),
    .advance_i    (seq_advance),
    .entry_cfg_o  (seq_cfg),
    .entry_last_o (seq_last),
    .at_first_o   (seq_at_first)
  );

  // ***********************************
  // read data
  // ***********************************
  logic [DW-1:0] rdata_reg, rdata_next;
  logic [DW-1:0] status_word;

  always_comb begin
    status_word                      = '0;
    status_word[`AAC_ST_NOT_EMPTY]   = fifo_not_empty;
    status_word[`AAC_ST_OVERFLOW]    = overflow_reg;
    status_word[`AAC_ST_OVERRUN]     = overrun_reg;
    status_word[`AAC_ST_ACQ_COMPLETE] = complete_reg;
    status_word[`AAC_ST_CONV_BUSY]   = conv_busy_reg;
    status_word[`AAC_ST_ACQ_ACTIVE]  = acq_run;
    status_word[`AAC_ST_COUNTING]    = (acq_state_reg == aac_pkg::AAC_ACQ_COUNTING);
    rdata_next = '0;
    if (rd_i) begin
      case (addr_i)
        // an empty fifo yields whatever the head slot holds
        `AAC_OFS_RESULT_FIFO:  rdata_next = fifo_head;
        `AAC_OFS_STATUS:       rdata_next = status_word;
        `AAC_OFS_COMMAND:      rdata_next = {{(DW-`AAC_CMD_W){1'b0}}, command_reg};
        `AAC_OFS_SAMPLE_IVAL:  rdata_next = sample_ival_reg;
        `AAC_OFS_SAMPLE_COUNT: rdata_next = sample_count_reg[DW-1:0];
        `AAC_OFS_SCAN_IVAL:    rdata_next = scan_ival_reg;
        default:               rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) rdata_reg <= '0;
    else            rdata_reg <= rdata_next;
  end

  assign rdata_o = rdata_reg;

endmodule : aac_top

`default_nettype wire

/* File: hw/aac_cfg.svh */
// constants of the acquisition control block: offsets, field positions, reset values, timing
`ifndef AAC_CFG_SVH
`define AAC_CFG_SVH

// ***********************************
// register offsets
// ***********************************
`define AAC_OFS_SOFT_CONVERT   8'h00
`define AAC_OFS_RESULT_FIFO    8'h04
`define AAC_OFS_STATUS         8'h08
`define AAC_OFS_COMMAND        8'h0c
`define AAC_OFS_ACQ_START      8'h10
`define AAC_OFS_ACQ_CLEAR      8'h14
`define AAC_OFS_SAMPLE_IVAL    8'h18
`define AAC_OFS_SAMPLE_COUNT   8'h1c
`define AAC_OFS_SCAN_IVAL      8'h20
`define AAC_OFS_CFG_MEM        8'h24
`define AAC_OFS_CFG_MEM_CLR    8'h28

// ***********************************
// command register fields
// ***********************************
`define AAC_CMD_SCAN_EN        0
`define AAC_CMD_ACQ_EN         1
`define AAC_CMD_SCAN_IVAL_EN   2
`define AAC_CMD_SCAN_DIV_EN    3
`define AAC_CMD_PRETRIG        4
`define AAC_CMD_INT_TIMING     5
`define AAC_CMD_W              6

// ***********************************
// status register fields
// ***********************************
`define AAC_ST_NOT_EMPTY       0
`define AAC_ST_OVERFLOW        1
`define AAC_ST_OVERRUN         2
`define AAC_ST_ACQ_COMPLETE    3
`define AAC_ST_CONV_BUSY       4
`define AAC_ST_ACQ_ACTIVE      5
`define AAC_ST_COUNTING        6

// ***********************************
// configuration memory entry fields
// ***********************************
`define AAC_CFG_LAST_BIT       15

// ***********************************
// reset values
// ***********************************
`define AAC_RST_COMMAND        6'h00
`define AAC_RST_SAMPLE_IVAL    16'h0002
`define AAC_RST_SAMPLE_COUNT   17'h00002
`define AAC_RST_SCAN_IVAL      16'h0002

// ***********************************
// timing
// ***********************************
`define AAC_CLK_PERIOD_NS      50
`define AAC_CONV_TIME_NS       10000

`endif

/* File: hw/aac_pkg.sv */
// types of the acquisition control block
package aac_pkg;

  typedef enum logic [1:0] {
    AAC_ACQ_IDLE,
    AAC_ACQ_PRE_WAIT,
    AAC_ACQ_COUNTING
  } aac_acq_state_t;

endpackage : aac_pkg

/* File: hw/aac_result_fifo.sv */
// result fifo: flip-flop storage with push, pop and clear
`timescale 1ns/1ps
`default_nettype none

module aac_result_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 512,
  parameter int AW    = 9
) (
  input  wire logic          mclk_i,
  input  wire logic          reset_n_i,
  input  wire logic          clear_i,
  input  wire logic          push_i,
  input  wire logic [W-1:0]  push_data_i,
  input  wire logic          pop_i,
  output logic      [W-1:0]  head_o,
  output logic               not_empty_o,
  output logic               full_o
);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg, wr_ptr_next;
  logic [AW-1:0] rd_ptr_reg, rd_ptr_next;
  logic [AW:0]   count_reg,  count_next;
  logic          do_push, do_pop;

  assign full_o      = (count_reg == (AW+1)'(DEPTH));
  assign not_empty_o = (count_reg != '0);
  assign head_o      = mem[rd_ptr_reg];
  // a push into a full fifo is dropped unless a pop frees the slot; the caller flags it
  assign do_push     = push_i && (!full_o || pop_i);
  assign do_pop      = pop_i && not_empty_o;

  always_comb begin
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    count_next  = count_reg;
    if (clear_i) begin
      wr_ptr_next = '0;
      rd_ptr_next = '0;
      count_next  = '0;
    end else begin
      if (do_push) wr_ptr_next = (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      if (do_pop)  rd_ptr_next = (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      if (do_push && !do_pop) count_next = count_reg + 1'b1;
      if (do_pop && !do_push) count_next = count_reg - 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg  <= count_next;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (do_push && !clear_i) mem[wr_ptr_reg] <= push_data_i;
  end

endmodule : aac_result_fifo

`default_nettype wire

/* File: hw/aac_scan_seq.sv */
// channel configuration memory with scan pointer
`include "aac_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module aac_scan_seq #(
  parameter int W     = 16,
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  input  wire logic          mclk_i,
  input  wire logic          reset_n_i,
  input  wire logic          clear_i,
  input  wire logic          write_i,
  input  wire logic [W-1:0]  write_data_i,
  input  wire logic          restart_i,
  input  wire logic          advance_i,
  output logic      [W-2:0]  entry_cfg_o,
  output logic               entry_last_o,
  output logic               at_first_o
);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg, wr_ptr_next;
  logic [AW-1:0] ptr_reg,    ptr_next;

  assign entry_cfg_o  = mem[ptr_reg][W-2:0];
  assign entry_last_o = mem[ptr_reg][`AAC_CFG_LAST_BIT];
  assign at_first_o   = (ptr_reg == '0);

  always_comb begin
    wr_ptr_next = wr_ptr_reg;
    ptr_next    = ptr_reg;
    if (clear_i) begin
      wr_ptr_next = '0;
      ptr_next    = '0;
    end else begin
      if (write_i && wr_ptr_reg != AW'(DEPTH-1)) wr_ptr_next = wr_ptr_reg + 1'b1;
      if (restart_i) begin
        ptr_next = '0;
      end else if (advance_i) begin
        // the marked entry ends the pass; a full memory also wraps
        if (entry_last_o || ptr_reg == AW'(DEPTH-1)) ptr_next = '0;
        else ptr_next = ptr_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_ptr_reg <= '0;
      ptr_reg    <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      ptr_reg    <= ptr_next;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (clear_i) begin
      mem[0] <= {1'b1, {(W-1){1'b0}}};
    end else if (write_i) begin
      mem[wr_ptr_reg] <= write_data_i;
    end
  end

endmodule : aac_scan_seq

`default_nettype wire

/* File: verif/aac_top_props.sv */
// port assertions of the acquisition control block
`timescale 1ns/1ps
`default_nettype none
module aac_top_props #(parameter int DW = 16) (
  input wire logic          mclk_i,
  input wire logic          reset_n_i,
  input wire logic [7:0]    addr_i,
  input wire logic          wr_i,
  input wire logic          rd_i,
  input wire logic [DW-1:0] rdata_o,
  input wire logic          adc_start_o,
  input wire logic [DW-2:0] adc_config_o,
  input wire logic          result_fifo_not_empty_o
);
  logic [7:0] busy_reg;
  logic [7:0] busy_next;
  logic       ne;
  assign ne = result_fifo_not_empty_o;
  // cycles left in the running conversion, 1 marks the push cycle
  always_comb busy_next = adc_start_o ? 8'hc8 : busy_reg - {7'h00, |busy_reg};
  always_ff @(posedge mclk_i or negedge reset_n_i)
    if (!reset_n_i) busy_reg <= 8'h00;
    else busy_reg <= busy_next;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_hit(logic [7:0] a);
    (wr_i || rd_i) && addr_i == a;
  endsequence
  chk_soft_start: assert property (s_hit(8'h00) ##0 busy_reg == 8'h00 |-> adc_start_o)
    else $error("soft strobe gave no start");
  chk_busy_refuse: assert property (adc_start_o |-> busy_reg < 8'h02)
    else $error("start while busy");
  chk_ne_cause: assert property ($rose(ne) |-> $past(busy_reg) == 8'h01)
    else $error("not-empty without push");
  chk_clear_empty: assert property (s_hit(8'h14) ##0 busy_reg != 8'h01 |=> !ne)
    else $error("clear left results");
  chk_ne_hold: assert property (ne && !rd_i && !wr_i |=> ne)
    else $error("not-empty dropped");
  chk_cfg_hold: assert property (busy_reg > 8'h01 && busy_reg < 8'hc8 |-> $stable(adc_config_o))
    else $error("config moved mid conversion");
  chk_busy_status: assert property (rd_i && addr_i == 8'h08 && busy_reg > 8'h02 |=> rdata_o[4])
    else $error("busy not shown");
  chk_read_idle: assert property (!$past(rd_i) |-> rdata_o == '0)
    else $error("read data outside read slot");
endmodule : aac_top_props
`default_nettype wire

/* File: verif/aac_far.sv */
// far side model: convert and trigger pins, converter data
`timescale 1ns/1ps
`default_nettype none
module aac_far (
  input  wire logic        mclk_i,
  input  wire logic        conv_i,
  input  wire logic        trig_i,
  output logic             conv_n_o,
  output logic             trig_n_o,
  output logic      [15:0] data_o
);
  initial {conv_n_o, trig_n_o, data_o} = {2'b11, 16'h0000};
  // data moves every cycle, so a mistimed sample is seen
  always @(posedge mclk_i) begin
    data_o   <= data_o + 16'h0001;
    conv_n_o <= !conv_i;
    trig_n_o <= !trig_i;
  end
endmodule : aac_far
`default_nettype wire

/* File: verif/adc_acquisition_control_bench.sv */
// self-checking bench of the acquisition control block
`timescale 1ns/1ps
`default_nettype none
module adc_acquisition_control_bench;
  logic        mclk_i = 1'b0, reset_n_i = 1'b0, wr = 1'b0, rd = 1'b0, cv = 1'b0, tg = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [15:0] wdata = 16'h0000, rdata, data, val, dat;
  logic [14:0] cfg;
  logic        cv_n, tg_n, start, ne;
  int          error_cnt = 0, n_compared = 0;
  always #25 mclk_i = ~mclk_i;
  aac_far u_far (.mclk_i(mclk_i), .conv_i(cv), .trig_i(tg), .conv_n_o(cv_n), .trig_n_o(tg_n),
    .data_o(data));
  aac_top u_dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .ext_convert_n_i(cv_n), .ext_trigger_n_i(tg_n),
    .counter_one_output_n_i(1'b1), .adc_data_i(data), .adc_start_o(start),
    .adc_config_o(cfg), .result_fifo_not_empty_o(ne));
  task automatic check(input string nm, input logic [15:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic summarize;
    if (error_cnt == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    {addr, wdata, wr} <= {a, d, 1'b1};
    #1 dat = data;
    @(posedge mclk_i);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a);
    @(posedge mclk_i);
    {addr, rd} <= {a, 1'b1};
    @(posedge mclk_i);
    rd <= 1'b0;
    #1 val = rdata;
  endtask : rd_reg
  task automatic pin(input bit trig);
    @(posedge mclk_i);
    {tg, cv} <= {trig, !trig};
    repeat (4) @(posedge mclk_i);
    {tg, cv} <= 2'b00;
  endtask : pin
  task automatic t_single;
    wr_reg(8'h00, 16'h0000);
    repeat (205) @(posedge mclk_i);
    check("not_empty", {15'h0000, ne}, 16'h0001);
    rd_reg(8'h04);
    check("result", val, dat + 16'h00c8);
    check("drained", {15'h0000, ne}, 16'h0000);
  endtask : t_single
  task automatic t_overrun;
    wr_reg(8'h00, 16'h0000);
    wr_reg(8'h00, 16'h0000);
    repeat (205) @(posedge mclk_i);
    rd_reg(8'h08);
    check("status", val & 16'h0007, 16'h0005);
    wr_reg(8'h14, 16'h0000);
    rd_reg(8'h08);
    check("cleared", val & 16'h000f, 16'h0000);
    pin(1'b0);
    repeat (210) @(posedge mclk_i);
    check("pin_conv", {15'h0000, ne}, 16'h0001);
    wr_reg(8'h14, 16'h0000);
  endtask : t_overrun
  task automatic t_acq;
    wr_reg(8'h18, 16'h00fa);
    wr_reg(8'h1c, 16'h0002);
    wr_reg(8'h20, 16'h0300);
    wr_reg(8'h24, 16'h0005);
    wr_reg(8'h24, 16'h8006);
    wr_reg(8'h0c, 16'h0027);
    for (int k = 0; k < 2; k++) begin
      if (k == 0) wr_reg(8'h10, 16'h0000);
      else pin(1'b1);
      val = 16'h0000;
      for (int i = 0; i < 60 && val[3] !== 1'b1; i++) begin
        repeat (20) @(posedge mclk_i);
        rd_reg(8'h08);
      end
      check("complete", val & 16'h0008, 16'h0008);
      check("scan_cfg", {1'b0, cfg}, 16'h0006);
      if (val[3] !== 1'b1) summarize();
      // long wait: the second sample lands here; the sample count of 2 ends the acquisition at the second start, so no third start follows
      repeat (460) @(posedge mclk_i);
      rd_reg(8'h04);
      check("first", {15'h0000, ne}, 16'h0001);
      rd_reg(8'h04);
      check("second", {15'h0000, ne}, 16'h0000);
      wr_reg(8'h14, 16'h0000);
    end
    wr_reg(8'h0c, 16'h0000);
  endtask : t_acq
  initial begin
    repeat (20) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    wr_reg(8'h28, 16'h0000);
    t_single();
    t_overrun();
    t_acq();
    summarize();
  end
endmodule : adc_acquisition_control_bench
bind aac_top aac_top_props #(.DW(DW)) u_props (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
  .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .adc_start_o(adc_start_o),
  .adc_config_o(adc_config_o), .result_fifo_not_empty_o(result_fifo_not_empty_o));
`default_nettype wire
